// ===== rtl/tuner_serial_port.sv
// tuner synthesizer serial programming port, two-wire and 3-wire modes
`timescale 1ns/1ps
`default_nettype none
module tuner_serial_port
  import tuner_serial_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_mode_select_pin,
  input wire logic [1:0] i_address_select,
  input wire logic i_enable_address_select_pin,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic [7:0] i_status_byte,
  output logic o_serial_data_out,
  output logic o_serial_data_oe,
  output logic [14:0] o_divider_ratio,
  output logic [7:0] o_control_byte,
  output logic [7:0] o_band_switch_byte,
  output logic o_reference_ratio_select_bit,
  output logic o_charge_pump_current,
  output logic o_high_band_port,
  output logic o_low_sub_band_port,
  output logic o_high_sub_band_port,
  output logic o_sound_trap_port,
  output logic o_update_pulse
);
  typedef struct packed {
    tw_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd;
    logic pair_open;
    logic pair_ctrl;
    logic master_ack;
    logic [6:0] div_hi;
    logic [14:0] divider;
    logic [7:0] control;
    logic [7:0] band;
    logic sda_oe;
    logic update;
    logic mode_prev;
    logic [26:0] tw_shift;
    logic [4:0] tw_cnt;
  } port_state_t;

  port_state_t q;
  port_state_t d;

  logic [LINE_COUNT-1:0] line_prev;
  logic [LINE_COUNT-1:0] line_rise;
  logic [LINE_COUNT-1:0] line_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;

  // edges of clock, data and enable lines
  line_edge_sampler u_sampler (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_lines({i_enable_address_select_pin, i_serial_data, i_serial_clk}),
    .o_prev(line_prev),
    .o_rise(line_rise),
    .o_fall(line_fall)
  );

  // bus conditions while the clock line is high
  assign start_seen = line_fall[LINE_DATA] & i_serial_clk & line_prev[LINE_CLK];
  assign stop_seen = line_rise[LINE_DATA] & i_serial_clk & line_prev[LINE_CLK];
  // address prefix plus the level-selected bits
  assign addr_match = (q.shreg[7:3] == ADDR_PREFIX) &&
                      (q.shreg[2:1] == i_address_select);

  // next-state logic for both bus modes
  always_comb begin
    d = q;
    d.update = 1'b0;
    d.mode_prev = i_bus_mode_select_pin;
    if (i_bus_mode_select_pin != q.mode_prev) begin
      // mode change abandons any transfer in progress
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
      d.tw_cnt = '0;
    end else if (i_bus_mode_select_pin) begin
      if (start_seen) begin
        d.st = ST_ADDR;
        d.bitcnt = '0;
        d.sda_oe = 1'b0;
        d.pair_open = 1'b0;
      end else if (stop_seen) begin
        d.st = ST_IDLE;
        d.sda_oe = 1'b0;
      end else begin
        case (q.st)
          ST_IDLE: begin
            d.sda_oe = 1'b0;
          end
          ST_ADDR, ST_WR_BYTE: begin
            if (line_rise[LINE_CLK] && q.bitcnt != BYTE_DONE) begin
              d.shreg = {q.shreg[6:0], i_serial_data};
              d.bitcnt = q.bitcnt + 4'h1;
            end else if (line_fall[LINE_CLK] && q.bitcnt == BYTE_DONE) begin
              d.bitcnt = '0;
              if (q.st == ST_ADDR) begin
                if (addr_match) begin
                  d.st = ST_ADDR_ACK;
                  d.sda_oe = 1'b1;
                  d.rd = q.shreg[0];
                end else begin
                  d.st = ST_IDLE;
                end
              end else begin
                // every written byte is acknowledged
                d.st = ST_WR_ACK;
                d.sda_oe = 1'b1;
                if (!q.pair_open) begin
                  // first byte of a pair: kind bit picks control or divider
                  d.pair_open = 1'b1;
                  d.pair_ctrl = q.shreg[BYTE_KIND_BIT];
                  if (q.shreg[BYTE_KIND_BIT]) begin
                    d.control = q.shreg;
                  end else begin
                    d.div_hi = q.shreg[6:0];
                  end
                end else begin
                  d.pair_open = 1'b0;
                  d.update = 1'b1;
                  if (q.pair_ctrl) begin
                    d.band = q.shreg;
                  end else begin
                    d.divider = {q.div_hi, q.shreg};
                  end
                end
              end
            end
          end
          ST_ADDR_ACK: begin
            if (line_fall[LINE_CLK]) begin
              if (q.rd) begin
                d.st = ST_RD_BYTE;
                d.shreg = i_status_byte;
                d.sda_oe = ~i_status_byte[7];
              end else begin
                d.st = ST_WR_BYTE;
                d.sda_oe = 1'b0;
              end
            end
          end
          ST_WR_ACK: begin
            if (line_fall[LINE_CLK]) begin
              d.st = ST_WR_BYTE;
              d.sda_oe = 1'b0;
            end
          end
          ST_RD_BYTE: begin
            if (line_rise[LINE_CLK] && q.bitcnt != BYTE_DONE) begin
              d.bitcnt = q.bitcnt + 4'h1;
            end else if (line_fall[LINE_CLK]) begin
              if (q.bitcnt == BYTE_DONE) begin
                d.st = ST_RD_ACK;
                d.sda_oe = 1'b0;
                d.bitcnt = '0;
              end else begin
                d.shreg = {q.shreg[6:0], 1'b0};
                d.sda_oe = ~q.shreg[6];
              end
            end
          end
          ST_RD_ACK: begin
            if (line_rise[LINE_CLK]) begin
              d.master_ack = ~i_serial_data;
            end else if (line_fall[LINE_CLK]) begin
              if (q.master_ack) begin
                // acknowledged: send the status byte again
                d.st = ST_RD_BYTE;
                d.shreg = i_status_byte;
                d.sda_oe = ~i_status_byte[7];
              end else begin
                d.st = ST_IDLE;
                d.sda_oe = 1'b0;
              end
            end
          end
          default: begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
          end
        endcase
      end
    end else begin
      // 3-wire mode: shift while enabled, decode on release
      d.st = ST_IDLE;
      d.sda_oe = 1'b0;
      if (line_rise[LINE_ENABLE]) begin
        d.tw_cnt = '0;
      end else if (i_enable_address_select_pin && line_rise[LINE_CLK]) begin
        d.tw_shift = {q.tw_shift[25:0], i_serial_data};
        if (q.tw_cnt != TW_CNT_MAX) begin
          d.tw_cnt = q.tw_cnt + 5'h01;
        end
      end else if (line_fall[LINE_ENABLE]) begin
        case (q.tw_cnt)
          TW_LEN_SHORT: begin
            // control byte untouched: ratio bit and current kept
            d.band[TW_PORT_BITS-1:0] = q.tw_shift[17:14];
            d.divider = {1'b0, q.tw_shift[13:0]};
            d.update = 1'b1;
          end
          TW_LEN_MID: begin
            d.band[TW_PORT_BITS-1:0] = q.tw_shift[18:15];
            d.divider = q.tw_shift[14:0];
            d.update = 1'b1;
          end
          TW_LEN_LONG: begin
            d.band[TW_PORT_BITS-1:0] = q.tw_shift[26:23];
            d.divider = q.tw_shift[22:8];
            d.control = q.tw_shift[7:0];
            d.update = 1'b1;
          end
          default: begin
            d.update = 1'b0;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.divider <= DIVIDER_RST;
      q.control <= CONTROL_RST;
      q.band <= BAND_RST;
      q.mode_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state flip-flops
  assign o_serial_data_out = q.update & 1'b0;
  assign o_serial_data_oe = q.sda_oe;
  assign o_divider_ratio = q.divider;
  assign o_control_byte = q.control;
  assign o_band_switch_byte = q.band;
  assign o_reference_ratio_select_bit = q.control[CTRL_RSB_BIT];
  assign o_charge_pump_current = q.control[CTRL_CP_BIT];
  assign o_high_band_port = q.band[BAND_HIGH_BIT];
  assign o_low_sub_band_port = q.band[BAND_LOW_SUB_BIT];
  assign o_high_sub_band_port = q.band[BAND_HIGH_SUB_BIT];
  assign o_sound_trap_port = q.band[BAND_TRAP_BIT];
  assign o_update_pulse = q.update;
endmodule
`default_nettype wire

// ===== rtl/tuner_serial_pkg.sv
// constants and types shared by the tuner synthesizer serial programming port
package tuner_serial_pkg;
  // sampled line indices
  localparam int LINE_COUNT = 3;
  localparam int LINE_CLK = 0;
  localparam int LINE_DATA = 1;
  localparam int LINE_ENABLE = 2;
  // two-wire address: fixed prefix, two selectable bits, read/write bit
  localparam logic [4:0] ADDR_PREFIX = 5'h18;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  // byte field positions
  localparam int BYTE_KIND_BIT = 7;
  localparam int CTRL_CP_BIT = 6;
  localparam int CTRL_RSB_BIT = 1;
  localparam int BAND_LOW_SUB_BIT = 0;
  localparam int BAND_HIGH_SUB_BIT = 1;
  localparam int BAND_HIGH_BIT = 2;
  localparam int BAND_TRAP_BIT = 3;
  // values after reset; control keeps the ratio select bit at one
  localparam logic [14:0] DIVIDER_RST = 15'h0000;
  localparam logic [7:0] CONTROL_RST = 8'h82;
  localparam logic [7:0] BAND_RST = 8'h00;
  // 3-wire transfer lengths and field layout
  localparam logic [4:0] TW_LEN_SHORT = 5'h12;
  localparam logic [4:0] TW_LEN_MID = 5'h13;
  localparam logic [4:0] TW_LEN_LONG = 5'h1B;
  localparam logic [4:0] TW_CNT_MAX = 5'h1F;
  localparam int TW_PORT_BITS = 4;
  // two-wire slave states, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } tw_state_t;
endpackage

// ===== rtl/line_edge_sampler.sv
// edge detection for the serial port input lines
`timescale 1ns/1ps
`default_nettype none
module line_edge_sampler
  import tuner_serial_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [LINE_COUNT-1:0] i_lines,
  output logic [LINE_COUNT-1:0] o_prev,
  output logic [LINE_COUNT-1:0] o_rise,
  output logic [LINE_COUNT-1:0] o_fall
);
  typedef struct packed {
    logic [LINE_COUNT-1:0] prev;
  } sampler_state_t;

  sampler_state_t state_reg;
  sampler_state_t state_next;

  // next state is simply the current line levels
  always_comb begin
    state_next = state_reg;
    state_next.prev = i_lines;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // start from the present levels so that no false edge follows reset
      state_reg <= state_next;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_prev = state_reg.prev;

  // one edge detector per line
  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_edge
      assign o_rise[gi] = i_lines[gi] & ~state_reg.prev[gi];
      assign o_fall[gi] = ~i_lines[gi] & state_reg.prev[gi];
    end
  endgenerate
endmodule
`default_nettype wire

// ===== tb/tuner_serial_port_asserts.sv
// assertions on the tuner serial port outputs
`timescale 1ns/1ps
`default_nettype none
module tuner_serial_port_chk
  import tuner_serial_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_bus_mode_select_pin,
  input wire logic i_enable_address_select_pin,
  input wire logic i_serial_clk,
  input wire logic o_serial_data_oe,
  input wire logic [14:0] o_divider_ratio,
  input wire logic [7:0] o_control_byte,
  input wire logic [7:0] o_band_switch_byte,
  input wire logic o_reference_ratio_select_bit,
  input wire logic o_charge_pump_current,
  input wire logic o_high_band_port,
  input wire logic o_low_sub_band_port,
  input wire logic o_high_sub_band_port,
  input wire logic o_sound_trap_port,
  input wire logic o_update_pulse
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // own count of clock rises inside the current 3-wire frame
  logic scl_prev;
  logic en_prev;
  logic [4:0] tw_len;
  always_ff @(posedge i_core_clk) begin
    scl_prev <= i_serial_clk;
    en_prev <= i_enable_address_select_pin;
    if (!i_rst_n) begin
      tw_len <= '0;
    end else if (i_enable_address_select_pin && !en_prev) begin
      tw_len <= '0;
    end else if (i_enable_address_select_pin && i_serial_clk && !scl_prev &&
                 tw_len != TW_CNT_MAX) begin
      tw_len <= tw_len + 5'h01;
    end
  end
  // 3-wire mode held, and enable held inside a 3-wire frame
  sequence s_three_wire;
    (!i_bus_mode_select_pin) [*3];
  endsequence
  sequence s_in_frame;
    (!i_bus_mode_select_pin && i_enable_address_select_pin) [*3];
  endsequence
  // settings and port bits
  property p_rst_vals;
    $rose(i_rst_n) |-> o_control_byte == 8'h82 && o_divider_ratio == 15'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values");
  // in 3-wire mode only a 27-bit transfer may move the ratio bit or the pump current
  property p_rsb_bit;
    !i_bus_mode_select_pin && $changed(o_reference_ratio_select_bit)
      |-> o_update_pulse && tw_len == TW_LEN_LONG;
  endproperty
  a_rsb_bit: assert property (p_rsb_bit) else $error("ratio bit");
  property p_cp_bit;
    !i_bus_mode_select_pin && $changed(o_charge_pump_current)
      |-> o_update_pulse && tw_len == TW_LEN_LONG;
  endproperty
  a_cp_bit: assert property (p_cp_bit) else $error("pump bit");
  // in 3-wire mode the port pins move only with an applied transfer
  property p_ports;
    !i_bus_mode_select_pin &&
      $changed({o_sound_trap_port, o_high_band_port, o_high_sub_band_port, o_low_sub_band_port})
      |-> o_update_pulse;
  endproperty
  a_ports: assert property (p_ports) else $error("band ports");
  // data line use and update timing
  property p_oe_3w;
    s_three_wire |-> !o_serial_data_oe;
  endproperty
  a_oe_3w: assert property (p_oe_3w) else $error("drive in 3-wire");
  property p_oe_scl;
    $changed(o_serial_data_oe) && i_bus_mode_select_pin && $past(i_bus_mode_select_pin, 2)
      |-> !i_serial_clk;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("drive change, clock high");
  property p_pulse_one;
    o_update_pulse |=> !o_update_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
  property p_tw_hold;
    s_in_frame |-> $stable(o_divider_ratio) && $stable(o_band_switch_byte);
  endproperty
  a_tw_hold: assert property (p_tw_hold) else $error("early apply");
endmodule
`default_nettype wire

// ===== tb/tuner_host_model.sv
// host master model for the tuner serial port
`timescale 1ns/1ps
`default_nettype none
module tuner_host_model (
  input wire logic i_core_clk,
  input wire logic i_dev_oe,
  output logic o_scl,
  output logic o_sda,
  output logic o_en
);
  logic r;
  // idle two-wire lines rest high on the pull-ups
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_en = 1'b0;
  end
  // a bus half period is four core cycles
  task automatic half();
    repeat (4) @(negedge i_core_clk);
  endtask
  task automatic start_c();
    o_sda = 1'b0;
    half();
    o_scl = 1'b0;
  endtask
  task automatic stop_c();
    @(negedge i_core_clk);
    o_sda = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda = 1'b1;
    half();
  endtask
  // one bit; the wired-and line is sampled with the clock high
  task automatic bit_io(input logic b, output logic q);
    @(negedge i_core_clk);
    o_sda = b;
    half();
    o_scl = 1'b1;
    half();
    q = o_sda & ~i_dev_oe;
    o_scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // no acknowledge after the last wanted byte
  task automatic rd_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~more, r);
  endtask
  // 3-wire frame, msb first; the clock rests low outside frames
  task automatic frame(input logic [26:0] v, input int n);
    o_scl = 1'b0;
    o_en = 1'b1;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      o_sda = v[i];
      half();
      o_scl = 1'b1;
      half();
      o_scl = 1'b0;
    end
    half();
    o_en = 1'b0;
    o_sda = ~o_sda;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ===== tb/test_tuner_serial_port.sv
// self-checking bench for the tuner serial port
`timescale 1ns/1ps
`default_nettype none
module test_tuner_serial_port;
  logic i_core_clk, i_rst_n, mode, scl, host_sda, en, sda, oe, ack, reference_ratio_select_bit, cp, pulse;
  logic [1:0] sel;
  logic [7:0] status, ctl, band, rd;
  logic sdo;
  logic [3:0] prt;
  logic [14:0] div;
  int error_cnt, samples_checked, npulse, p0;
  assign sda = host_sda & ~oe; // wired-and data line
  tuner_host_model u_host (.i_core_clk, .i_dev_oe(oe), .o_scl(scl), .o_sda(host_sda), .o_en(en));
  tuner_serial_port u_dut (
    .i_core_clk, .i_rst_n, .i_bus_mode_select_pin(mode), .i_address_select(sel),
    .i_enable_address_select_pin(en), .i_serial_clk(scl), .i_serial_data(sda),
    .i_status_byte(status), .o_serial_data_out(sdo), .o_serial_data_oe(oe),
    .o_divider_ratio(div), .o_control_byte(ctl), .o_band_switch_byte(band),
    .o_reference_ratio_select_bit(reference_ratio_select_bit), .o_charge_pump_current(cp), .o_high_band_port(prt[2]),
    .o_low_sub_band_port(prt[0]), .o_high_sub_band_port(prt[1]), .o_sound_trap_port(prt[3]),
    .o_update_pulse(pulse));
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // pulses are counted away from the edge that launches them
  always @(negedge i_core_clk) begin
    if (pulse === 1'b1) npulse++;
  end
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // two-wire write of n bytes, every acknowledge expected as ea
  task automatic wr(input logic [7:0] a, input logic [31:0] b, input int n, input logic ea);
    u_host.start_c();
    u_host.wr_byte(a, ack);
    chk(ack === ea, "address ack");
    for (int i = n - 1; i >= 0; i--) begin
      u_host.wr_byte(b[8*i +: 8], ack);
      chk(ack === ea, "data ack");
    end
    u_host.stop_c();
  endtask
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    mode = 1'b1;
    sel = 2'b01;
    status = 8'hA5;
    repeat (5) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk(div === 15'h0000 && ctl === 8'h82 && band === 8'h00 && reference_ratio_select_bit === 1'b1, "reset");
    wr(8'hC2, 32'h0640CE09, 4, 1'b1);
    chk(div === 15'h0640 && ctl === 8'hCE && band === 8'h09, "order one");
    chk(npulse === 2 && prt === 4'h9 && sdo === 1'b0, "order one pins");
    wr(8'hC2, 32'hCE090123, 4, 1'b1);
    chk(div === 15'h0123 && ctl === 8'hCE && band === 8'h09, "order two");
    wr(8'hC2, 32'h0640, 2, 1'b1);
    chk(div === 15'h0640 && ctl === 8'hCE && band === 8'h09, "divider only");
    wr(8'hC2, 32'h8605, 2, 1'b1);
    chk(div === 15'h0640 && ctl === 8'h86 && band === 8'h05, "control only");
    sel = 2'b10;
    wr(8'hC2, 32'h0111, 2, 1'b0);
    wr(8'hC4, 32'h1111, 2, 1'b1);
    chk(div === 15'h1111, "address select");
    u_host.start_c();
    u_host.wr_byte(8'hC5, ack);
    chk(ack === 1'b1, "read ack");
    u_host.rd_byte(1'b1, rd);
    chk(rd === 8'hA5, "status one");
    status = 8'h3C; // repeated byte is loaded afresh
    u_host.rd_byte(1'b0, rd);
    chk(rd === 8'h3C, "status two");
    u_host.stop_c();
    chk(oe === 1'b0, "read end");
    mode = 1'b0;
    p0 = npulse;
    u_host.frame({4'hA, 15'h1234, 8'h40}, 27);
    chk(div === 15'h1234 && band[3:0] === 4'hA && ctl === 8'h40, "long frame");
    chk(reference_ratio_select_bit === 1'b0 && cp === 1'b1, "long frame bits");
    chk(prt === 4'hA, "long frame ports");
    // later dividers are computed for the kept ratio
    u_host.frame({8'h00, 4'h5, 15'h0ABC}, 19);
    chk(div === 15'h0ABC && band[3:0] === 4'h5 && ctl === 8'h40, "mid frame");
    u_host.frame({9'h000, 4'h3, 14'h1555}, 18);
    chk(div === 15'h1555 && band[3:0] === 4'h3 && reference_ratio_select_bit === 1'b0, "short frame");
    chk(prt === 4'h3 && cp === 1'b1, "short frame ports");
    chk(npulse === p0 + 3, "pulses");
    u_host.frame({7'h00, 20'hFFFFF}, 20);
    wr(8'hC4, 32'h2222, 2, 1'b0);
    chk(div === 15'h1555 && npulse === p0 + 3, "ignored");
    // a second reset brings back the power-on settings, ratio bit at one
    i_rst_n = 1'b0;
    repeat (5) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    chk(div === 15'h0000 && ctl === 8'h82 && reference_ratio_select_bit === 1'b1 && prt === 4'h0, "reset 2");
    test_done();
  end
endmodule
bind tuner_serial_port tuner_serial_port_chk u_chk (
  .i_core_clk, .i_rst_n, .i_bus_mode_select_pin, .i_enable_address_select_pin,
  .i_serial_clk, .o_serial_data_oe, .o_divider_ratio, .o_control_byte,
  .o_band_switch_byte, .o_reference_ratio_select_bit, .o_charge_pump_current,
  .o_high_band_port, .o_low_sub_band_port, .o_high_sub_band_port, .o_sound_trap_port,
  .o_update_pulse);
`default_nettype wire
